//--- tef_tx_element_format.sv
// Overview of operation
// RQ1: Host places standard id in bits 28:18
// RQ2: Copy marker low byte into event
// RQ3: Event store bit zero writes no event
// RQ4: Capture enable pulses sync output one cycle
// RQ5: Format bit selects classic or FD frame
// RQ6: Rate switch bit selects bit rate switching
// RQ7: Error, format, switch bits need FD enabled
// RQ8: Switch bit also needs rate switch enable
// RQ9: Codes 0-8 literal, 9-15 give 12..64
// RQ10: Classic frame codes 9-15 carry eight
// RQ11: Marker high byte only in wide modes
// RQ12: Data bytes packed little-endian from word two
// RQ13: Element size limits data words fetched
// RQ14: Events written in transmission order
// RQ15: Plain mode puts timestamp in event word
// RQ16: Wide modes put marker high byte there
// RQ17: Capture sets flag and register index
// RQ18: Without capture flag clear, index invalid
// RQ19: Event type 01 normal, 10 despite cancel
// RQ20: Timestamp latched at frame start
// RQ21: Sent error indicator ORs error passive
// RQ22: Memory accessed only as whole words
//
// Local design decisions: the APB interface to the registers and the address map.
module tef_tx_element_format
  import tef_pkg::*;
(
  input  wire logic          i_clock,
  input  wire logic          i_reset_n,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  output tef_mem_req_type    o_mem,
  input  wire logic          i_mem_ack,
  input  wire logic [31:0]   i_mem_rdata,
  input  wire logic          i_tx_request,
  input  wire logic [13:0]   i_tx_buffer_addr,
  output logic               o_tx_busy,
  output tef_frame_type      o_frame,
  output logic               o_frame_valid,
  output logic               o_data_valid,
  output logic [3:0]         o_data_index,
  output logic [31:0]        o_data_word,
  input  wire logic          i_error_passive,
  input  wire logic          i_frame_start,
  input  wire logic [15:0]   i_timestamp,
  input  wire logic          i_frame_sent,
  input  wire logic          i_frame_dropped,
  input  wire logic          i_sent_despite_cancel,
  input  wire logic [3:0]    i_stamp_index,
  output logic               o_sync_tx
);

  typedef struct packed {
    tef_state_type   state;
    logic            fd_operation_enable;
    logic            rate_switch_enable;
    logic            wide_marker_enable;
    logic            external_stamp_unit_mode;
    logic [2:0]      tx_element_size_config;
    logic            dar_mode;
    logic [13:0]     evt_base;
    logic [5:0]      evt_size;
    logic [5:0]      put;
    logic [5:0]      get;
    logic            full;
    logic            lost;
    logic [13:0]     buf_addr;
    logic [31:0]     t0;
    logic [31:0]     t1;
    logic [4:0]      word_idx;
    logic [4:0]      word_total;
    logic [15:0]     tx_start_timestamp;
    logic [3:0]      stamp_register_index;
    logic            despite;
    tef_mem_req_type mem;
    tef_frame_type   frame;
    logic            frame_valid;
    logic            data_valid;
    logic [3:0]      data_index;
    logic [31:0]     data_word;
    logic            sync_tx;
  } tef_regs_type;

  tef_regs_type r;
  tef_regs_type next_r;

  logic          apb_wr;
  logic          mem_done;
  logic          fd_ok;
  logic          brs_ok;
  logic          wide_form;
  logic          capture;
  logic          event_store_enable;
  logic [3:0]    dlc;
  logic [6:0]    bytes;
  logic [6:0]    elem_bytes;
  logic [4:0]    need_words;
  logic [4:0]    elem_words;
  logic [5:0]    fill;
  logic [5:0]    put_inc;
  logic [31:0]   e1;
  logic [31:0]   ctrl_rd;
  logic [31:0]   status_rd;

  assign apb_wr   = psel && penable && pwrite;
  assign mem_done = r.mem.req && i_mem_ack;
  assign pready   = 1'b1;

  assign fd_ok      = r.fd_operation_enable && !r.t0[TEF_T0_RTR_POS]; // [RQ7]
  assign brs_ok     = fd_ok && r.rate_switch_enable; // [RQ8]
  assign wide_form  = r.wide_marker_enable || r.external_stamp_unit_mode; // [RQ11]
  assign capture    = r.external_stamp_unit_mode && r.t1[TEF_T1_SYNC_CAPTURE_ENABLE_POS];
  assign event_store_enable = r.t1[TEF_T1_EFC_POS];
  assign dlc        = r.t1[TEF_T1_DLC_LSB +: 4];
  assign elem_bytes = tef_code_bytes(r.tx_element_size_config + 4'h8); // [RQ13]
  assign elem_words = elem_bytes[6:2];
  assign put_inc    = (r.put + 6'h01 >= r.evt_size) ? 6'h00 : r.put + 6'h01;
  assign fill       = r.full ? r.evt_size :
                      (r.put >= r.get) ? r.put - r.get : r.put + r.evt_size - r.get;

  always_comb
  begin
    bytes = 7'h00;
    if (!r.t0[TEF_T0_RTR_POS])
    begin
      if (fd_ok && r.t1[TEF_T1_FDF_POS])
        bytes = tef_code_bytes(dlc); // [RQ9]
      else if (dlc > TEF_CLASSIC_MAX_DLC)
        bytes = 7'h08; // [RQ10]
      else
        bytes = {3'h0, dlc}; // [RQ9]
    end
    need_words = 5'(({1'b0, bytes} + 8'h03) >> 2);
    if (need_words > elem_words)
      need_words = elem_words; // [RQ13]
  end

  // Second event word: marker form or timestamp form
  always_comb
  begin
    e1 = 32'h0000_0000;
    e1[31:24] = r.t1[31:24]; // [RQ2]
    e1[23:22] = (r.despite || r.dar_mode) ? TEF_ET_DESPITE : TEF_ET_TX; // [RQ19]
    e1[21]    = r.frame.fdf;
    e1[20]    = r.frame.brs;
    e1[19:16] = dlc;
    if (wide_form)
    begin
      e1[15:8] = r.t1[TEF_T1_MMHI_LSB +: 8]; // [RQ16]
      e1[TEF_E1_TSC_POS] = capture; // [RQ17] [RQ18]
      e1[3:0]  = capture ? r.stamp_register_index : 4'h0; // [RQ17]
    end
    else
      e1[15:0] = r.tx_start_timestamp; // [RQ15]
  end

  always_comb
  begin
    ctrl_rd = 32'h0000_0000;
    ctrl_rd[TEF_CTRL_FD_POS]   = r.fd_operation_enable;
    ctrl_rd[TEF_CTRL_BRS_POS]  = r.rate_switch_enable;
    ctrl_rd[TEF_CTRL_WMM_POS]  = r.wide_marker_enable;
    ctrl_rd[TEF_CTRL_UTSU_POS] = r.external_stamp_unit_mode;
    ctrl_rd[TEF_CTRL_ESZ_LSB +: 3] = r.tx_element_size_config;
    ctrl_rd[TEF_CTRL_DAR_POS]  = r.dar_mode;
    status_rd = 32'h0000_0000;
    status_rd[TEF_ST_FILL_LSB +: 6] = fill;
    status_rd[TEF_ST_GET_LSB +: 6]  = r.get;
    status_rd[TEF_ST_PUT_LSB +: 6]  = r.put;
    status_rd[TEF_ST_FULL_POS]      = r.full;
    status_rd[TEF_ST_LOST_POS]      = r.lost;
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    case (paddr)
      TEF_CTRL_OFF:     prdata = ctrl_rd;
      TEF_EVT_BASE_OFF: prdata = {16'h0000, r.evt_base, 2'h0};
      TEF_EVT_SIZE_OFF: prdata = {26'h0, r.evt_size};
      TEF_EVT_GET_OFF:  prdata = {26'h0, r.get};
      TEF_STATUS_OFF:   prdata = status_rd;
      default:          pslverr = psel && penable;
    endcase
  end

  always_comb
  begin
    next_r = r;
    next_r.frame_valid = 1'b0;
    next_r.data_valid  = 1'b0;
    next_r.sync_tx     = 1'b0;

    if (apb_wr)
    begin
      case (paddr)
        TEF_CTRL_OFF:
        begin
          next_r.fd_operation_enable      = pwdata[TEF_CTRL_FD_POS];
          next_r.rate_switch_enable       = pwdata[TEF_CTRL_BRS_POS];
          next_r.wide_marker_enable       = pwdata[TEF_CTRL_WMM_POS];
          next_r.external_stamp_unit_mode = pwdata[TEF_CTRL_UTSU_POS];
          next_r.tx_element_size_config   = pwdata[TEF_CTRL_ESZ_LSB +: 3];
          next_r.dar_mode                 = pwdata[TEF_CTRL_DAR_POS];
        end
        TEF_EVT_BASE_OFF: next_r.evt_base = pwdata[15:2];
        TEF_EVT_SIZE_OFF: next_r.evt_size = (pwdata[5:0] == 6'h00) ? 6'h01 : pwdata[5:0];
        TEF_EVT_GET_OFF:
        begin
          // Host hands back elements by advancing the read index
          next_r.get  = (pwdata[5:0] >= r.evt_size) ? 6'h00 : pwdata[5:0];
          next_r.full = 1'b0;
        end
        TEF_STATUS_OFF:
          if (pwdata[TEF_ST_LOST_POS])
            next_r.lost = 1'b0;
        default: ;
      endcase
    end

    case (r.state)
      TEF_IDLE:
        if (i_tx_request)
        begin
          next_r.buf_addr   = i_tx_buffer_addr;
          next_r.mem        = '{req: 1'b1, we: 1'b0, addr: i_tx_buffer_addr,
                                wdata: 32'h0000_0000}; // [RQ22]
          next_r.despite    = 1'b0;
          next_r.state      = TEF_RD_T0;
        end
      TEF_RD_T0:
        if (mem_done)
        begin
          next_r.t0       = i_mem_rdata;
          next_r.mem.addr = r.buf_addr + 14'h0001;
          next_r.state    = TEF_RD_T1;
        end
      TEF_RD_T1:
        if (mem_done)
        begin
          next_r.t1       = i_mem_rdata;
          next_r.mem.req  = 1'b0;
          next_r.word_idx = 5'h00;
          next_r.state    = TEF_RD_DB;
        end
      TEF_RD_DB:
      begin
        // T1 is now stable, so the frame header is resolved here on every cycle of this state
        next_r.frame.esi = (fd_ok && r.t0[TEF_T0_ESI_POS]) || i_error_passive; // [RQ21] [RQ7]
        next_r.frame.extended_id_flag = r.t0[TEF_T0_XTD_POS];
        next_r.frame.rtr = r.t0[TEF_T0_RTR_POS];
        next_r.frame.id  = r.t0[28:0]; // [RQ1]
        next_r.frame.fdf = fd_ok && r.t1[TEF_T1_FDF_POS]; // [RQ5]
        next_r.frame.brs = brs_ok && r.t1[TEF_T1_FDF_POS] && r.t1[TEF_T1_BRS_POS]; // [RQ6]
        next_r.frame.dlc = dlc;
        next_r.frame.data_bytes = bytes;
        next_r.word_total = need_words;
        if (mem_done)
        begin
          // Words pass as read: byte 0 stays in bits 7:0
          next_r.data_valid = 1'b1; // [RQ12]
          next_r.data_word  = i_mem_rdata;
          next_r.data_index = r.word_idx[3:0];
          next_r.word_idx   = r.word_idx + 5'h01;
          next_r.mem.req    = 1'b0;
        end
        else if (!r.mem.req)
        begin
          if (r.word_idx < need_words)
          begin
            next_r.mem.req  = 1'b1;
            next_r.mem.addr = r.buf_addr + TEF_DATA_WORD_OFS + {9'h000, r.word_idx}; // [RQ12]
          end
          else
          begin
            next_r.frame_valid = 1'b1;
            next_r.state       = TEF_SEND;
          end
        end
      end
      TEF_SEND:
      begin
        if (i_frame_start)
          next_r.tx_start_timestamp = i_timestamp; // [RQ20]
        if (i_frame_dropped)
          next_r.state = TEF_IDLE;
        else if (i_frame_sent)
        begin
          next_r.sync_tx = capture; // [RQ4]
          next_r.stamp_register_index = i_stamp_index; // [RQ17]
          next_r.despite = i_sent_despite_cancel;
          if (!event_store_enable)
            next_r.state = TEF_IDLE; // [RQ3]
          else if (r.full)
          begin
            // No room: the event is dropped and flagged rather than overwriting
            next_r.lost  = 1'b1;
            next_r.state = TEF_IDLE;
          end
          else
          begin
            next_r.mem = '{req: 1'b1, we: 1'b1,
                           addr: r.evt_base + {7'h00, r.put, 1'b0},
                           wdata: {r.frame.esi, r.t0[30:0]}}; // [RQ3] [RQ22]
            next_r.state = TEF_WR_E0;
          end
        end
      end
      TEF_WR_E0:
        if (mem_done)
        begin
          next_r.mem.addr  = r.mem.addr + 14'h0001;
          next_r.mem.wdata = e1;
          next_r.state     = TEF_WR_E1;
        end
      TEF_WR_E1:
        if (mem_done)
        begin
          next_r.mem.req = 1'b0;
          next_r.mem.we  = 1'b0;
          next_r.put     = put_inc; // [RQ14]
          next_r.full    = (put_inc == next_r.get) && !(apb_wr && paddr == TEF_EVT_GET_OFF &&
                           next_r.get != r.get) ? 1'b1 : (put_inc == next_r.get);
          next_r.state   = TEF_IDLE;
        end
      default: next_r.state = TEF_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      r                        <= '0;
      r.state                  <= TEF_IDLE;
      r.evt_base               <= TEF_EVT_BASE_RST;
      r.evt_size               <= TEF_EVT_SIZE_RST;
      r.tx_element_size_config <= TEF_ESZ_RST;
    end
    else
      r <= next_r;
  end

  assign o_mem         = r.mem;
  assign o_tx_busy     = (r.state != TEF_IDLE);
  assign o_frame       = r.frame;
  assign o_frame_valid = r.frame_valid;
  assign o_data_valid  = r.data_valid;
  assign o_data_index  = r.data_index;
  assign o_data_word   = r.data_word;
  assign o_sync_tx     = r.sync_tx; // [RQ4]

endmodule // tef_tx_element_format

//--- tef_pkg.sv
package tef_pkg;

  // APB register byte offsets
  localparam logic [7:0] TEF_CTRL_OFF      = 8'h00;
  localparam logic [7:0] TEF_EVT_BASE_OFF  = 8'h04;
  localparam logic [7:0] TEF_EVT_SIZE_OFF  = 8'h08;
  localparam logic [7:0] TEF_EVT_GET_OFF   = 8'h0c;
  localparam logic [7:0] TEF_STATUS_OFF    = 8'h10;

  // Control register fields
  localparam int TEF_CTRL_FD_POS   = 0;
  localparam int TEF_CTRL_BRS_POS  = 1;
  localparam int TEF_CTRL_WMM_POS  = 2;
  localparam int TEF_CTRL_UTSU_POS = 3;
  localparam int TEF_CTRL_ESZ_LSB  = 4;
  localparam int TEF_CTRL_DAR_POS  = 8;

  // Status register fields
  localparam int TEF_ST_FILL_LSB = 0;
  localparam int TEF_ST_GET_LSB  = 8;
  localparam int TEF_ST_PUT_LSB  = 16;
  localparam int TEF_ST_FULL_POS = 24;
  localparam int TEF_ST_LOST_POS = 25;

  // Reset values
  localparam logic [5:0]  TEF_EVT_SIZE_RST = 6'h10;
  localparam logic [13:0] TEF_EVT_BASE_RST = 14'h0000;
  localparam logic [2:0]  TEF_ESZ_RST      = 3'h0;

  // Buffer word 0 and 1 and event word 1 field positions
  localparam int TEF_T0_ESI_POS  = 31;
  localparam int TEF_T0_XTD_POS  = 30;
  localparam int TEF_T0_RTR_POS  = 29;
  localparam int TEF_T0_STD_LSB  = 18;
  localparam int TEF_T1_MMLO_LSB = 24;
  localparam int TEF_T1_EFC_POS  = 23;
  localparam int TEF_T1_SYNC_CAPTURE_ENABLE_POS = 22;
  localparam int TEF_T1_FDF_POS  = 21;
  localparam int TEF_T1_BRS_POS  = 20;
  localparam int TEF_T1_DLC_LSB  = 16;
  localparam int TEF_T1_MMHI_LSB = 8;
  localparam int TEF_E1_TSC_POS  = 4;

  localparam logic [1:0] TEF_ET_TX      = 2'h1;
  localparam logic [1:0] TEF_ET_DESPITE = 2'h2;
  localparam logic [3:0] TEF_CLASSIC_MAX_DLC = 4'h8;
  localparam logic [13:0] TEF_DATA_WORD_OFS  = 14'h0002;

  typedef enum logic [6:0] {
    TEF_IDLE  = 7'h01,
    TEF_RD_T0 = 7'h02,
    TEF_RD_T1 = 7'h04,
    TEF_RD_DB = 7'h08,
    TEF_SEND  = 7'h10,
    TEF_WR_E0 = 7'h20,
    TEF_WR_E1 = 7'h40
  } tef_state_type;

  typedef struct packed {
    logic        esi;
    logic        extended_id_flag;
    logic        rtr;
    logic        fdf;
    logic        brs;
    logic [3:0]  dlc;
    logic [28:0] id;
    logic [6:0]  data_bytes;
  } tef_frame_type;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [13:0] addr;
    logic [31:0] wdata;
  } tef_mem_req_type;

  // Byte count of a length code in the long-frame coding
  function automatic logic [6:0] tef_code_bytes(input logic [3:0] code);
    case (code)
      4'h9:    tef_code_bytes = 7'h0c;
      4'ha:    tef_code_bytes = 7'h10;
      4'hb:    tef_code_bytes = 7'h14;
      4'hc:    tef_code_bytes = 7'h18;
      4'hd:    tef_code_bytes = 7'h20;
      4'he:    tef_code_bytes = 7'h30;
      4'hf:    tef_code_bytes = 7'h40;
      default: tef_code_bytes = {3'h0, code};
    endcase
  endfunction

endpackage

//--- tef_mem_model.sv
module tef_mem_model
  import tef_pkg::*;
(
  input  wire logic            i_clock,
  input  wire logic            i_reset_n,
  input  wire tef_mem_req_type i_mem,
  input  wire logic [1:0]      i_wait,
  output logic                 o_ack,
  output logic [31:0]          o_rdata
);
  logic [31:0] words [0:16383];
  logic [1:0]  cnt;
  // Read data toggles outside an answer, so a stale sample never matches
  always @(posedge i_clock or negedge i_reset_n)
    if (!i_reset_n)
    begin
      o_ack   <= 1'b0;
      cnt     <= 2'h0;
      o_rdata <= 32'h0;
    end
    else
    begin
      o_rdata <= ~o_rdata;
      o_ack   <= 1'b0;
      if (o_ack && i_mem.we)
        words[i_mem.addr] <= i_mem.wdata;
      if (i_mem.req && !o_ack)
      begin
        cnt <= cnt + 2'h1;
        if (cnt >= i_wait)
        begin
          o_ack   <= 1'b1;
          cnt     <= 2'h0;
          o_rdata <= words[i_mem.addr];
        end
      end
    end
endmodule // tef_mem_model

//--- tef_tx_element_format_monitor.sv
module tef_tx_element_format_monitor
  import tef_pkg::*;
(
  input wire logic            i_clock,
  input wire logic            i_reset_n,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [7:0]      paddr,
  input wire logic [31:0]     pwdata,
  input wire tef_mem_req_type o_mem,
  input wire logic            i_mem_ack,
  input wire logic            i_tx_request,
  input wire logic            o_tx_busy,
  input wire tef_frame_type   o_frame,
  input wire logic            o_frame_valid,
  input wire logic            o_data_valid,
  input wire logic [3:0]      o_data_index,
  input wire logic            i_error_passive,
  input wire logic            i_frame_sent,
  input wire logic            o_sync_tx
);
  logic [8:0] ctrl;
  logic [3:0] idx_exp;
  logic       sent_seen;
  // Shadow of the mode bits, so checks follow what software set
  always_ff @(posedge i_clock or negedge i_reset_n)
    if (!i_reset_n)
    begin
      ctrl      <= 9'h000;
      idx_exp   <= 4'h0;
      sent_seen <= 1'b0;
    end
    else
    begin
      if (psel && penable && pwrite && paddr == TEF_CTRL_OFF)
        ctrl <= pwdata[8:0];
      if (i_tx_request && !o_tx_busy)
        idx_exp <= 4'h0;
      else if (o_data_valid)
        idx_exp <= idx_exp + 4'h1;
      sent_seen <= o_tx_busy && (sent_seen || i_frame_sent);
    end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  sequence s_sync;
    o_sync_tx ##1 !o_sync_tx;
  endsequence
  property p_sync_one;
    o_sync_tx |-> s_sync;
  endproperty
  a_sync_one: assert property (p_sync_one) else $error("sync pulse too long");
  property p_sync_cause;
    o_sync_tx |-> ctrl[3] && $past(i_frame_sent);
  endproperty
  a_sync_cause: assert property (p_sync_cause) else $error("sync pulse uncaused");
  property p_mem_hold;
    o_mem.req && !i_mem_ack |=> o_mem.req && $stable(o_mem);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("memory request dropped");
  property p_data_order;
    o_data_valid |-> o_data_index == idx_exp;
  endproperty
  a_data_order: assert property (p_data_order) else $error("data word order");
  property p_fd_gate;
    o_frame_valid && !ctrl[0] |-> !o_frame.fdf && !o_frame.brs;
  endproperty
  a_fd_gate: assert property (p_fd_gate) else $error("fd bits used while off");
  property p_brs_gate;
    o_frame_valid && !ctrl[1] |-> !o_frame.brs;
  endproperty
  a_brs_gate: assert property (p_brs_gate) else $error("switch bit used while off");
  property p_classic_len;
    o_frame_valid && !o_frame.fdf && !o_frame.rtr |->
      o_frame.data_bytes == ((o_frame.dlc > 4'h8) ? 7'h08 : {3'h0, o_frame.dlc});
  endproperty
  a_classic_len: assert property (p_classic_len) else $error("classic length");
  property p_esi_or;
    o_frame_valid && i_error_passive |-> o_frame.esi;
  endproperty
  a_esi_or: assert property (p_esi_or) else $error("error indicator low");
  property p_write_after_sent;
    o_mem.req && o_mem.we |-> sent_seen;
  endproperty
  a_write_after_sent: assert property (p_write_after_sent) else $error("early event");
endmodule // tef_tx_element_format_monitor
bind tef_tx_element_format tef_tx_element_format_monitor u_mon (.i_clock, .i_reset_n, .psel,
  .penable, .pwrite, .paddr, .pwdata, .o_mem, .i_mem_ack, .i_tx_request, .o_tx_busy, .o_frame,
  .o_frame_valid, .o_data_valid, .o_data_index, .i_error_passive, .i_frame_sent, .o_sync_tx);

//--- tef_tx_element_format_tb.sv
module tef_tx_element_format_tb
  import tef_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic            i_clock = 1'b0;
  logic            i_reset_n = 1'b0;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [7:0]      paddr = 8'h00;
  logic [31:0]     pwdata = 32'h0;
  logic [31:0]     prdata, o_data_word, i_mem_rdata;
  logic            pready, pslverr, i_mem_ack, o_tx_busy, o_frame_valid, o_data_valid, o_sync_tx;
  tef_mem_req_type o_mem;
  tef_frame_type   o_frame;
  logic [3:0]      o_data_index;
  logic            req = 1'b0, ep = 1'b0, fs = 1'b0, sent = 1'b0, drop = 1'b0, dsp = 1'b0;
  logic [15:0]     ts = 16'h0;
  logic [3:0]      sidx = 4'h0;
  logic [1:0]      mwait = 2'h0;
  logic [31:0]     got [16];
  logic [8:0]      ctrl = 9'h0;
  logic [5:0]      put = 6'h0;
  int              ndw, nsync, miscompares, n_compared;
  always #2.5 i_clock = ~i_clock;
  tef_tx_element_format dut (.i_clock, .i_reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .o_mem, .i_mem_ack, .i_mem_rdata, .i_tx_request(req),
    .i_tx_buffer_addr(14'h0100), .o_tx_busy, .o_frame, .o_frame_valid, .o_data_valid,
    .o_data_index, .o_data_word, .i_error_passive(ep), .i_frame_start(fs), .i_timestamp(ts),
    .i_frame_sent(sent), .i_frame_dropped(drop), .i_sent_despite_cancel(dsp),
    .i_stamp_index(sidx), .o_sync_tx);
  tef_mem_model mem (.i_clock, .i_reset_n, .i_mem(o_mem), .i_wait(mwait), .o_ack(i_mem_ack),
    .o_rdata(i_mem_rdata));
  always @(posedge i_clock)
  begin
    if (o_data_valid === 1'b1)
      got[o_data_index] = o_data_word;
    ndw += (o_data_valid === 1'b1);
    nsync += (o_sync_tx === 1'b1);
  end
  function automatic int lb(input logic [3:0] c);
    int t[16] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 12, 16, 20, 24, 32, 48, 64};
    return t[c];
  endfunction
  task automatic check(input string n, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge i_clock);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge i_clock);
    penable <= 1'b1;
    do @(posedge i_clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic setc(input logic [8:0] c);
    logic [31:0] r;
    logic        e;
    ctrl = c;
    apb(1'b1, TEF_CTRL_OFF, {23'h0, c}, r, e);
  endtask
  // Flags: 0 error passive, 1 sent despite cancel, 2 dropped, 3 slow memory
  task automatic frame(input logic [31:0] t0, t1, input logic [3:0] fl);
    logic        fd, br, es, tc, wd, e;
    logic [6:0]  nb;
    logic [15:0] tsv;
    logic [3:0]  si;
    logic [31:0] s, h, e1;
    int          nw;
    fd = ctrl[0] & t1[21] & ~t0[29];
    br = fd & ctrl[1] & t1[20];
    es = (ctrl[0] & t0[31]) | fl[0];
    tc = ctrl[3] & t1[22];
    wd = ctrl[2] | ctrl[3];
    nb = t0[29] ? 7'h0 : 7'((t1[19:16] > 4'h8 && !fd) ? 8 : lb(t1[19:16]));
    nw = (nb + 3) / 4;
    if (nw > lb({1'b1, ctrl[6:4]}) / 4)
      nw = lb({1'b1, ctrl[6:4]}) / 4;
    tsv = t1[31:16] ^ 16'h5a5a;
    si = t1[3:0] ^ 4'h9;
    mem.words[256] = t0;
    mem.words[257] = t1;
    for (int i = 0; i < 16; i++)
      mem.words[258 + i] = 32'h03020100 + 32'h04040404 * i;
    ndw = 0;
    nsync = 0;
    @(posedge i_clock);
    {req, ep, mwait} <= {1'b1, fl[0], fl[3], fl[3]};
    @(posedge i_clock);
    req <= 1'b0;
    for (int k = 0; k < 900 && o_frame_valid !== 1'b1; k++) @(posedge i_clock);
    h = {o_frame.esi, o_frame.extended_id_flag, o_frame.rtr, o_frame.fdf, o_frame.brs, o_frame.dlc};
    check("hdr", {h[8:0], o_frame.data_bytes}, {es, t0[30:29], fd, br, t1[19:16], nb});
    check("id", o_frame.id, t0[28:0]);
    check("words", ndw, nw);
    for (int i = 0; i < nw; i++)
      check("data", got[i], mem.words[258 + i]);
    @(posedge i_clock);
    {fs, ts} <= {1'b1, tsv};
    @(posedge i_clock);
    {fs, ts} <= {1'b0, ~tsv};
    repeat (3) @(posedge i_clock);
    {sent, drop, dsp, sidx} <= {~fl[2], fl[2], fl[1], si};
    @(posedge i_clock);
    {sent, drop, sidx} <= {2'b00, ~si};
    for (int k = 0; k < 900 && o_tx_busy !== 1'b0; k++) @(posedge i_clock);
    check("sync", nsync, tc & ~fl[2]);
    e1 = {t1[31:24], (fl[1] | ctrl[8]) ? 2'h2 : 2'h1, fd, br, t1[19:16], 16'h0};
    e1[15:0] = wd ? {t1[15:8], 3'h0, tc, tc ? si : 4'h0} : tsv;
    if (t1[23] && !fl[2])
    begin
      check("ev0", mem.words[2 * put], {es, t0[30:0]});
      check("ev1", mem.words[2 * put + 1], e1);
      put = (put + 6'h1) % 6'h10;
      apb(1'b1, TEF_EVT_GET_OFF, {26'h0, put}, s, e);
    end
    // The write index has already moved on once the event is stored
    apb(1'b0, TEF_STATUS_OFF, 32'h0, s, e);
    check("put", s[21:16], put);
    $display("frame %h %h done", t0, t1);
  endtask
  task automatic close_out;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (n_compared > 0 && miscompares == 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge i_clock);
    miscompares++;
    close_out;
  end
  initial
  begin
    logic [31:0] r;
    logic        e;
    repeat (6) @(posedge i_clock);
    i_reset_n <= 1'b1;
    apb(1'b0, TEF_CTRL_OFF, 32'h0, r, e);
    check("ctrl", r, 32'h0);
    apb(1'b0, TEF_EVT_SIZE_OFF, 32'h0, r, e);
    check("size", r, 32'h10);
    apb(1'b1, 8'h14, 32'hffff, r, e);
    check("slverr", e, 1'b1);
    $display("registers done");
    for (int c = 0; c < 32; c++)
    begin
      setc(c[0] ? 9'h073 : 9'h070);
      frame({3'h0, 11'(c * 37), 18'h0}, {8'(c), 4'hb, 4'(c >> 1), 16'h5c00}, 4'(c & 8));
    end
    setc(9'h000);
    frame(32'hc12345a7, 32'h11bf7700, 4'h0);
    setc(9'h001);
    frame(32'h80000000, 32'h22b94400, 4'h1);
    setc(9'h00b);
    frame(32'h20000000, 32'h33ff9900, 4'h8);
    frame(32'h0abc0000, 32'h44ba6600, 4'h0);
    setc(9'h00c);
    frame(32'h1fffffff, 32'h55b3a500, 4'h2);
    setc(9'h104);
    frame(32'h04440000, 32'h66b23c00, 4'h0);
    setc(9'h001);
    frame(32'h05550000, 32'h77280000, 4'h0);
    frame(32'h06660000, 32'h88a50000, 4'h4);
    close_out;
  end
endmodule // tef_tx_element_format_tb
